// File: logic/ambient_light_result_regs.sv
// Purpose: Read-only identity and result registers of a light sensor.
// Assumes: The serial-bus engine issues reads on this clock.
// Notes:   Answers come one cycle after the request.
//
// Notes on behaviour
// - Identity register at Ah, read-only, constant.
// - Identity holds part code 7:4, revision 3:0.
// - Each result is 16 bits over two bytes.
// - Channel 0 low at Ch, high at Dh.
// - Channel 1 low at Eh, high at Fh.
// - Result registers read-only, zero after reset.
// - Low read latches upper byte for later.
// - Latched upper byte survives later conversions.
// - Word read at low address returns both bytes.
`timescale 1ns/10ps
`include "alr_defs.svh"

module ambient_light_result_regs
  import alr_pkg::*;
#(
  // Identity codes; the default values are arbitrary.
  parameter logic [3:0] PART_CODE = 4'h5,
  parameter logic [3:0] REV_CODE = 4'h1
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Read requests from the serial-bus engine
  input wire rd_req_type i_rd,
  // Conversion results
  input wire logic i_conv_done,
  input wire result_type i_chan0_value,
  input wire result_type i_chan1_value,
  // Read answer
  output logic o_rd_valid,
  output logic o_rd_hit,
  output logic [15:0] o_rd_data
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire logic [7:0] identity_value;
  wire logic hit_identity;
  wire logic hit_result;
  wire logic is_low;
  wire logic chan_sel;
  result_type live [`ALR_NUM_CHAN];
  logic [7:0] shadow [`ALR_NUM_CHAN];
  wire logic [`ALR_NUM_CHAN-1:0] capture;
  wire result_type chan_values [`ALR_NUM_CHAN];

  assign identity_value[`ALR_PART_MSB:`ALR_PART_LSB] = PART_CODE;
  assign identity_value[`ALR_REV_MSB:`ALR_REV_LSB] = REV_CODE;
  assign hit_identity = (i_rd.addr == `ALR_ADDR_IDENTITY);
  // Ch..Fh: bit 1 picks the channel, bit 0 picks the byte.
  assign hit_result =
    (i_rd.addr[3:2] == 2'(`ALR_ADDR_CH0_LOW >> 2));
  assign chan_sel = i_rd.addr[1];
  assign is_low = ~i_rd.addr[0];
  assign chan_values[0] = i_chan0_value;
  assign chan_values[1] = i_chan1_value;

  // ---------------------------------------------------------------
  // Channel stores
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `ALR_NUM_CHAN; g = g + 1) begin : g_chan
      // Word reads also capture, so a later byte read of the high half
      // still matches the word.
      assign capture[g] = i_rd.strobe & hit_result & is_low &
                          (chan_sel == 1'(g));
      chan_result_store u_store (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_update(i_conv_done),
        .i_value(chan_values[g]),
        .i_capture(capture[g]),
        .o_live(live[g]),
        .o_shadow(shadow[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read data select
  // ---------------------------------------------------------------
  wire result_type sel_live;
  wire logic [7:0] sel_shadow;
  wire logic [15:0] result_data;
  wire logic [15:0] read_data;

  assign sel_live = chan_sel ? live[1] : live[0];
  assign sel_shadow = chan_sel ? shadow[1] : shadow[0];
  // Live value, not shadow, for the word: both bytes from one sample.
  assign result_data = !is_low ? {8'h00, sel_shadow} :
                       i_rd.word ? sel_live :
                       {8'h00, sel_live[7:0]};
  assign read_data = hit_identity ? {8'h00, identity_value} :
                     hit_result ? result_data : 16'h0000;

  logic rd_valid_q;
  logic rd_hit_q;
  logic [15:0] rd_data_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_valid_q <= 1'b0;
      rd_hit_q <= 1'b0;
      rd_data_q <= 16'h0000;
    end else begin
      rd_valid_q <= i_rd.strobe;
      rd_hit_q <= i_rd.strobe & (hit_identity | hit_result);
      if (i_rd.strobe) begin
        rd_data_q <= read_data;
      end
    end
  end

  assign o_rd_valid = rd_valid_q;
  assign o_rd_hit = rd_hit_q;
  assign o_rd_data = rd_data_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  wire logic rd_low0 = i_rd.strobe && i_rd.addr == `ALR_ADDR_CH0_LOW;
  wire logic rd_high0 = i_rd.strobe && i_rd.addr == `ALR_ADDR_CH0_HIGH;
  wire logic rd_low1 = i_rd.strobe && i_rd.addr == `ALR_ADDR_CH1_LOW;
  wire logic rd_high1 = i_rd.strobe && i_rd.addr == `ALR_ADDR_CH1_HIGH;

  a_answer_one_cycle: assert property (
    i_rd.strobe |=> o_rd_valid ##1 (!o_rd_valid || $past(i_rd.strobe))
  ) else $error("read answer not exactly one cycle later");

  a_identity_fixed: assert property (
    (i_rd.strobe && i_rd.addr == `ALR_ADDR_IDENTITY) |=>
      o_rd_hit && o_rd_data == {8'h00, PART_CODE, REV_CODE}
  ) else $error("identity read returned wrong value");

  a_low_captures_high: assert property (
    rd_low0 |=> shadow[0] == $past(live[0][15:8])
  ) else $error("low read did not latch upper byte");

  a_high_gives_shadow: assert property (
    (rd_low0 && !i_rd.word) ##1 (rd_high0 && !i_rd.word) |=>
      o_rd_data == {8'h00, $past(live[0][15:8], 2)}
  ) else $error("upper byte read not coherent with low read");

  a_shadow_holds: assert property (
    (i_conv_done && !capture[0]) |=> $stable(shadow[0])
  ) else $error("shadow moved without a low read");

  a_live_updates: assert property (
    i_conv_done |=> live[0] == $past(i_chan0_value) &&
                    live[1] == $past(i_chan1_value)
  ) else $error("live result not updated at conversion end");

  a_word_pair: assert property (
    (rd_low1 && i_rd.word) |=> o_rd_data == $past(live[1])
  ) else $error("word read did not return both bytes");

  a_low_byte_ch1: assert property (
    (rd_low1 && !i_rd.word) |=> o_rd_data == {8'h00, $past(live[1][7:0])}
  ) else $error("channel 1 low byte wrong");

  a_unmapped_zero: assert property (
    (i_rd.strobe && !hit_identity && !hit_result) |=>
      !o_rd_hit && o_rd_data == 16'h0000
  ) else $error("unmapped read not answered with zero");

  a_low_byte_ch0: assert property (
    (rd_low0 && !i_rd.word) |=> o_rd_data == {8'h00, $past(live[0][7:0])}
  ) else $error("channel 0 low byte wrong");

  a_word_pair_ch0: assert property (
    (rd_low0 && i_rd.word) |=> o_rd_data == $past(live[0])
  ) else $error("channel 0 word read did not return both bytes");

  a_ch1_captures: assert property (
    rd_low1 |=> shadow[1] == $past(live[1][15:8])
  ) else $error("channel 1 low read did not latch upper byte");

  a_ch1_shadow_holds: assert property (
    (i_conv_done && !capture[1]) |=> $stable(shadow[1])
  ) else $error("channel 1 shadow moved without a low read");

  a_ch1_high_byte: assert property (
    (rd_high1 && !i_rd.word) |=> o_rd_data == {8'h00, $past(shadow[1])}
  ) else $error("channel 1 upper byte not taken from the shadow");

  a_mapped_hit: assert property (
    (i_rd.strobe && (hit_identity || hit_result)) |=> o_rd_valid && o_rd_hit
  ) else $error("mapped read not flagged as hit");

  // Read data is sticky, so a host that samples late still sees its data.
  a_data_holds: assert property (
    !i_rd.strobe |=> $stable(o_rd_data)
  ) else $error("read data moved without a read");

  a_no_strobe_quiet: assert property (
    !i_rd.strobe |=> !o_rd_valid && !o_rd_hit
  ) else $error("answer given without a read");

  // ---------------------------------------------------------------
  // Covers
  // ---------------------------------------------------------------
  c_word_read: cover property (rd_low1 && i_rd.word);
  c_byte_pair: cover property (rd_low0 ##1 rd_high0);
  c_conv_between: cover property (rd_low0 ##1 i_conv_done ##1 rd_high0);
  c_identity: cover property (i_rd.strobe && hit_identity);

endmodule // ambient_light_result_regs

// File: logic/alr_defs.svh
// Purpose: Offsets, field positions and reset values of the result bank.
// Assumes: Four-bit register addresses, byte-wide registers.
// Notes:   Definitions only.
`ifndef ALR_DEFS_SVH
`define ALR_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ALR_ADDR_IDENTITY 4'hA
`define ALR_ADDR_CH0_LOW 4'hC
`define ALR_ADDR_CH0_HIGH 4'hD
`define ALR_ADDR_CH1_LOW 4'hE
`define ALR_ADDR_CH1_HIGH 4'hF

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define ALR_PART_MSB 7
`define ALR_PART_LSB 4
`define ALR_REV_MSB 3
`define ALR_REV_LSB 0
`define ALR_RESULT_RESET 16'h0000
`define ALR_BYTE_RESET 8'h00
`define ALR_NUM_CHAN 2

`endif

// File: logic/alr_pkg.sv
// Purpose: Types shared by the result bank and its channel stores.
// Assumes: Nothing beyond the constants header.
// Notes:   Carries the read request as one packed struct.
package alr_pkg;

  typedef struct packed {
    logic strobe;
    logic word;
    logic [3:0] addr;
  } rd_req_type;

  typedef logic [15:0] result_type;

endpackage

// File: logic/chan_result_store.sv
// Purpose: Live result and upper-byte shadow of one conversion channel.
// Assumes: Update and capture come from logic on the same clock.
// Notes:   A capture samples the live value before a same-cycle update.
`timescale 1ns/10ps
`include "alr_defs.svh"

module chan_result_store
  import alr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Conversion side
  input wire logic i_update,
  input wire result_type i_value,
  // Read side
  input wire logic i_capture,
  output result_type o_live,
  output logic [7:0] o_shadow
);

  result_type live_q;
  logic [7:0] shadow_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      live_q <= `ALR_RESULT_RESET;
    end else if (i_update) begin
      live_q <= i_value;
    end
  end

  // The shadow only moves on a read at the low address, byte or word, so later conversions
  // cannot tear a pending upper-byte read.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      shadow_q <= `ALR_BYTE_RESET;
    end else if (i_capture) begin
      shadow_q <= live_q[15:8];
    end
  end

  assign o_live = live_q;
  assign o_shadow = shadow_q;

endmodule // chan_result_store

// File: verif/alr_host_model.sv
// Purpose: Serial-bus engine side that issues reads to the result bank.
// Assumes: One read at a time; the answer is sampled after its edge.
// Notes:   Released request fields show the inverse of the last value.
`timescale 1ns/10ps

module alr_host_model
  import alr_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Request out
  output rd_req_type o_rd,
  // Answer in
  input wire logic i_valid,
  input wire logic i_hit,
  input wire logic [15:0] i_data
);
  initial o_rd = '0;

  // The caller orders low before high and may ask a word read.
  task automatic rd(input logic [3:0] a, input logic w, output logic v,
                    output logic h, output logic [15:0] d);
    @(posedge i_clk);
    o_rd <= '{1'b1, w, a};
    @(posedge i_clk);
    // Stale fields are flipped so nothing can lean on them.
    o_rd <= '{1'b0, ~w, ~a};
    #1;
    v = i_valid;
    h = i_hit;
    d = i_data;
  endtask

  // Two byte reads on consecutive edges, low before high.
  task automatic rd2(input logic [3:0] a0, input logic [3:0] a1,
                     output logic [1:0] v, output logic [1:0] h,
                     output logic [31:0] d);
    @(posedge i_clk);
    o_rd <= '{1'b1, 1'b0, a0};
    @(posedge i_clk);
    o_rd <= '{1'b1, 1'b0, a1};
    #1;
    v[0] = i_valid;
    h[0] = i_hit;
    d[15:0] = i_data;
    @(posedge i_clk);
    o_rd <= '{1'b0, 1'b1, ~a1};
    #1;
    v[1] = i_valid;
    h[1] = i_hit;
    d[31:16] = i_data;
  endtask
endmodule // alr_host_model

// File: verif/ambient_light_result_regs_tb_top.sv
// Purpose: Self-checking bench of the result bank against a bench model.
// Assumes: Answers one cycle after the strobe edge.
// Notes:   Identity codes below are arbitrary.
`timescale 1ns/10ps

module ambient_light_result_regs_tb_top
  import alr_pkg::*;
;
  localparam logic [3:0] PART = 4'h9;
  localparam logic [3:0] REV = 4'h3;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_conv_done = 1'b0;
  result_type i_chan0_value = '0;
  result_type i_chan1_value = '0;
  rd_req_type rd;
  logic o_rd_valid, o_rd_hit;
  logic [15:0] o_rd_data;
  int n_errors = 0;
  int check_count = 0;
  int live[2] = '{0, 0};
  int sh[2] = '{0, 0};

  always #10 i_clk = ~i_clk;

  ambient_light_result_regs #(.PART_CODE(PART), .REV_CODE(REV)) uut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_rd(rd),
    .i_conv_done(i_conv_done), .i_chan0_value(i_chan0_value),
    .i_chan1_value(i_chan1_value), .o_rd_valid(o_rd_valid),
    .o_rd_hit(o_rd_hit), .o_rd_data(o_rd_data));

  alr_host_model host (.i_clk(i_clk), .o_rd(rd), .i_valid(o_rd_valid),
    .i_hit(o_rd_hit), .i_data(o_rd_data));

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic conv(int v0, int v1);
    @(posedge i_clk);
    i_conv_done <= 1'b1;
    i_chan0_value <= 16'(v0);
    i_chan1_value <= 16'(v1);
    live[0] = v0 & 16'hffff;
    live[1] = v1 & 16'hffff;
    @(posedge i_clk);
    i_conv_done <= 1'b0;
  endtask

  // Bench model of one read; a read at a low address, byte or word, moves the shadow.
  function automatic logic [15:0] model_rd(logic [3:0] a, logic w);
    logic [15:0] e;
    int ch;
    ch = int'(a[1]);
    e = 16'h0000;
    if (a == 4'hA) e = {8'h00, PART, REV};
    else if (a >= 4'hC && !a[0]) begin
      e = w ? 16'(live[ch]) : {8'h00, 8'(live[ch])};
      sh[ch] = (live[ch] >> 8) & 8'hff;
    end else if (a >= 4'hC) e = {8'h00, 8'(sh[ch])};
    return e;
  endfunction

  task automatic compare(logic [3:0] a, logic w, logic v, logic h,
                         logic [15:0] d);
    check("valid", {15'h0000, v}, 16'h0001);
    check("hit", {15'h0000, h},
          {15'h0000, a == 4'hA || a >= 4'hC});
    check("data", d, model_rd(a, w));
  endtask

  task automatic do_rd(input logic [3:0] a, input logic w);
    logic v, h;
    logic [15:0] d;
    host.rd(a, w, v, h, d);
    compare(a, w, v, h, d);
  endtask

  task automatic do_pair(input logic [3:0] a0, input logic [3:0] a1);
    logic [1:0] v, h;
    logic [31:0] d;
    host.rd2(a0, a1, v, h, d);
    compare(a0, 1'b0, v[0], h[0], d[15:0]);
    compare(a1, 1'b0, v[1], h[1], d[31:16]);
  endtask

  initial begin
    void'($urandom(32'hf1ca));
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int a = 0; a < 16; a++) do_rd(4'(a), 1'b0);
    for (int i = 0; i < 40; i++) begin
      conv($urandom, $urandom);
      do_rd(4'hC + 4'(2 * (i % 2)), 1'b0);
      conv($urandom, $urandom);
      do_rd(4'hD + 4'(2 * (i % 2)), 1'b0);
      do_rd(4'($urandom_range(15, 0)), 1'($urandom_range(1, 0)));
      do_rd(4'hC + 4'(2 * (i % 2)), 1'b1);
      do_rd(4'hD + 4'(2 * (i % 2)), 1'b1);
      do_rd(4'hA, 1'b0);
      do_pair(4'hC + 4'(2 * (i % 2)),
              4'hD + 4'(2 * (i % 2)));
    end
    final_report();
  end

  initial begin
    #200000;
    n_errors++;
    final_report();
  end
endmodule // ambient_light_result_regs_tb_top
